// File: srhc_pkg.sv
// Package for the host-side controller of an asynchronous 256K x 16 static memory.
// Assumes a 200 MHz reference clock; all timing counts are derived from it.
package srhc_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;

    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 5000;

    // Minimum cycle and pulse times in nanoseconds (slower speed grade)
    localparam int T_CYCLE_NS = 70;
    localparam int T_WRITE_PULSE_NS = 60;
    localparam int T_DATA_SETUP_NS = 30;
    localparam int T_OUT_HIZ_NS = 25;

    // Least times round up to whole clock cycles
    localparam int CYC_CYCLE = (T_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_WRITE_PULSE = (T_WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_DATA_SETUP = (T_DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_TURNAROUND = (T_OUT_HIZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int CNT_W = 5;

    // Pin levels after reset: all strobes inactive
    localparam logic RST_STROBE_N = 1'h1;
    localparam logic [ADDR_W-1:0] RST_ADDR = 18'h00000;
    localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_READ = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_RECOVER = 5'b01000,
        ST_RETAIN = 5'b10000
    } srhc_state_t;

endpackage : srhc_pkg

// File: srhc_sync.sv
// Two flip-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to i_ref_clk.
`timescale 1ns/1ps
module srhc_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule : srhc_sync

// File: srhc_ctrl.sv
// Host controller driving an asynchronous 256K x 16 static memory through its pins.
// Assumes the memory sits directly on the pins; read data is synchronised before capture.
`timescale 1ns/1ps
// Overview of operation
// - One shared 16-bit bus; memory drives only during enabled reads.
// - Write window opens at the last falling strobe.
// - Write window closes at first rising strobe; data then is stored.
// - Host holds address stable from before window open until after close; this host loads it on the same edge the strobes fall.
// - Chip-select retention: host holds chip select high; others may float.
// - Byte-select retention: byte selects high, chip select low.
module srhc_ctrl
    import srhc_pkg::*;
#(
    parameter int ADDR_WIDTH = srhc_pkg::ADDR_W,
    parameter int DATA_WIDTH = srhc_pkg::DATA_W
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // User request
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [ADDR_WIDTH-1:0] i_req_addr,
    input wire logic [DATA_WIDTH-1:0] i_req_wdata,
    input wire logic [1:0] i_req_byte_en,
    output logic o_req_ready,
    // User response
    output logic o_rsp_valid,
    output logic [DATA_WIDTH-1:0] o_rsp_rdata,
    // Retention control
    input wire logic i_retain_req,
    input wire logic i_retain_by_bytes,
    output logic o_retain_active,
    // Memory pins
    output logic [ADDR_WIDTH-1:0] o_word_address,
    output logic o_chip_select_n,
    output logic o_write_enable_n,
    output logic o_output_enable_n,
    output logic o_lower_byte_select_n,
    output logic o_upper_byte_select_n,
    input wire logic [DATA_WIDTH-1:0] i_shared_data_bus,
    output logic [DATA_WIDTH-1:0] o_shared_data_bus,
    output logic [DATA_WIDTH-1:0] o_shared_data_bus_oe
);
    import srhc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Sampled data bus

    logic [DATA_WIDTH-1:0] bus_sync;

    srhc_sync #(
        .WIDTH(DATA_WIDTH)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_async(i_shared_data_bus),
        .o_sync(bus_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and counters

    srhc_state_t state_ff;
    srhc_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [ADDR_WIDTH-1:0] addr_ff;
    logic [DATA_WIDTH-1:0] wdata_ff;
    logic [1:0] ben_ff;
    logic retain_bytes_ff;
    logic [DATA_WIDTH-1:0] rdata_ff;
    logic rsp_valid_ff;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction : cyc

    // Read must span cycle time plus synchroniser latency before capture
    localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(CYC_CYCLE + 2 - 1);
    // Write strobe held low for the whole cycle time; the count starts at zero
    localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(CYC_CYCLE - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + cyc(1);
        unique case (state_ff)
            ST_IDLE: begin
                nxt_cnt = '0;
                if (i_retain_req) begin
                    nxt_state = ST_RETAIN;
                end else if (i_req_valid && (i_req_byte_en != 2'h0)) begin
                    nxt_state = i_req_write ? ST_WRITE : ST_READ;
                end
            end
            ST_READ: begin
                if (cnt_ff == READ_LAST) begin
                    nxt_state = ST_RECOVER;
                    nxt_cnt = '0;
                end
            end
            ST_WRITE: begin
                if (cnt_ff == WRITE_LAST) begin
                    nxt_state = ST_RECOVER;
                    nxt_cnt = '0;
                end
            end
            ST_RECOVER: begin
                // Lets the memory release the bus before the next access
                if (cnt_ff == cyc(CYC_TURNAROUND - 1)) begin
                    nxt_state = ST_IDLE;
                    nxt_cnt = '0;
                end
            end
            ST_RETAIN: begin
                nxt_cnt = '0;
                if (!i_retain_req) begin
                    nxt_state = ST_RECOVER;
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request capture; address held for the whole access

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            addr_ff <= RST_ADDR;
            wdata_ff <= RST_DATA;
            ben_ff <= 2'h0;
            retain_bytes_ff <= 1'h0;
        end else if (state_ff == ST_IDLE) begin
            addr_ff <= i_req_addr;
            wdata_ff <= i_req_wdata;
            ben_ff <= i_req_byte_en;
            retain_bytes_ff <= i_retain_by_bytes;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive, all from flip-flops

    logic cs_n_ff;
    logic we_n_ff;
    logic oe_n_ff;
    logic lb_n_ff;
    logic ub_n_ff;
    logic drive_ff;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cs_n_ff <= RST_STROBE_N;
            we_n_ff <= RST_STROBE_N;
            oe_n_ff <= RST_STROBE_N;
            lb_n_ff <= RST_STROBE_N;
            ub_n_ff <= RST_STROBE_N;
            drive_ff <= 1'h0;
        end else begin
            cs_n_ff <= 1'h1;
            we_n_ff <= 1'h1;
            oe_n_ff <= 1'h1;
            lb_n_ff <= 1'h1;
            ub_n_ff <= 1'h1;
            drive_ff <= 1'h0;
            unique case (nxt_state)
                ST_READ: begin
                    cs_n_ff <= 1'h0;
                    oe_n_ff <= 1'h0;
                    lb_n_ff <= ~((state_ff == ST_IDLE) ? i_req_byte_en[0] : ben_ff[0]);
                    ub_n_ff <= ~((state_ff == ST_IDLE) ? i_req_byte_en[1] : ben_ff[1]);
                end
                ST_WRITE: begin
                    // Window opens on write falling, closes on all strobes rising together
                    cs_n_ff <= 1'h0;
                    we_n_ff <= 1'h0;
                    lb_n_ff <= ~((state_ff == ST_IDLE) ? i_req_byte_en[0] : ben_ff[0]);
                    ub_n_ff <= ~((state_ff == ST_IDLE) ? i_req_byte_en[1] : ben_ff[1]);
                    drive_ff <= 1'h1;
                end
                ST_RECOVER: begin
                    // Data held one more cycle past the window close
                    drive_ff <= (state_ff == ST_WRITE);
                end
                ST_RETAIN: begin
                    // Retention kind is taken on entry and held for the whole stay
                    cs_n_ff <= (state_ff == ST_IDLE) ? ~i_retain_by_bytes : ~retain_bytes_ff;
                end
                ST_IDLE: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read capture

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_ff <= RST_DATA;
            rsp_valid_ff <= 1'h0;
        end else begin
            rsp_valid_ff <= 1'h0;
            if (state_ff == ST_READ && cnt_ff == READ_LAST) begin
                rdata_ff[7:0] <= ben_ff[0] ? bus_sync[7:0] : 8'h00;
                rdata_ff[15:8] <= ben_ff[1] ? bus_sync[15:8] : 8'h00;
                rsp_valid_ff <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_req_ready = (state_ff == ST_IDLE) && !i_retain_req;
    assign o_rsp_valid = rsp_valid_ff;
    assign o_rsp_rdata = rdata_ff;
    assign o_retain_active = (state_ff == ST_RETAIN);
    assign o_word_address = addr_ff;
    assign o_chip_select_n = cs_n_ff;
    assign o_write_enable_n = we_n_ff;
    assign o_output_enable_n = oe_n_ff;
    assign o_lower_byte_select_n = lb_n_ff;
    assign o_upper_byte_select_n = ub_n_ff;
    assign o_shared_data_bus = wdata_ff;
    // Drive only while write is low or just after; output enable is never low then
    assign o_shared_data_bus_oe = {DATA_WIDTH{drive_ff}};

endmodule : srhc_ctrl

// File: srhc_mem_model.sv
// Behavioural 256K x 16 static memory standing on the controller pins.
// Assumes the bench resolves the shared bus from the host's enable alone.
`timescale 1ns/1ps
module srhc_mem_model #(
    parameter int T_ACC_NS = 55,
    parameter int T_HZ_NS = 20
) (
    // Host pins, strobes as {chip, write, output, upper, lower}
    input wire logic [17:0] i_addr,
    input wire logic [4:0] i_strb_n,
    input wire logic [15:0] i_dq,
    // Memory side of the bus
    output logic [15:0] o_dq,
    output logic [1:0] o_drv = 2'h0
);
    logic [15:0] mem [logic [17:0]];
    logic [15:0] wd = 16'h0000;
    logic [1:0] wl = 2'h0;
    logic [15:0] rw;
    logic wr_q = 1'h0;
    logic wr_now;
    wire cs = !i_strb_n[4];
    wire rd = cs && i_strb_n[3] && !i_strb_n[2];
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] word(input logic [17:0] a);
        if ($isunknown(a) || !mem.exists(a))
            return ~a[15:0];
        return mem[a];
    endfunction : word
    // Lanes gather while the window is open, so a staggered close cannot drop one
    always @(i_addr, i_strb_n, i_dq) begin
        wr_now = !i_strb_n[4] && !i_strb_n[3] && i_strb_n[1:0] != 2'h3;
        if (wr_q && !wr_now) begin
            rw = word(i_addr);
            if (!$isunknown(i_addr))
                mem[i_addr] = {wl[1] ? wd[15:8] : rw[15:8], wl[0] ? wd[7:0] : rw[7:0]};
            wl = 2'h0;
        end
        if (wr_now) begin
            wd = i_dq;
            wl = wl | ~i_strb_n[1:0];
        end
        wr_q = wr_now;
        rw = word(i_addr);
    end
    always @(rd, i_strb_n[1:0]) begin
        if (rd)
            o_drv <= #(T_ACC_NS) ~i_strb_n[1:0];
        else
            o_drv <= #(T_HZ_NS) 2'h0;
    end
    // Released lanes show the inverse so a stale capture cannot pass
    assign o_dq = {o_drv[1] ? rw[15:8] : ~rw[15:8], o_drv[0] ? rw[7:0] : ~rw[7:0]};
endmodule : srhc_mem_model

// File: srhc_ctrl_sva.sv
// Pin-level assertions for the static memory host controller.
// Assumes binding into srhc_ctrl; one clock, active-high reset.
`timescale 1ns/1ps
module srhc_ctrl_chk #(
    parameter int ADDR_WIDTH = 18,
    parameter int DATA_WIDTH = 16
) (
    // Clock, reset and user side
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [ADDR_WIDTH-1:0] i_req_addr,
    input wire logic [1:0] i_req_byte_en,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire logic o_retain_active,
    // Memory pins
    input wire logic [ADDR_WIDTH-1:0] o_word_address,
    input wire logic o_chip_select_n,
    input wire logic o_write_enable_n,
    input wire logic o_output_enable_n,
    input wire logic o_lower_byte_select_n,
    input wire logic o_upper_byte_select_n,
    input wire logic [DATA_WIDTH-1:0] o_shared_data_bus_oe
);
    wire wr_on = !o_chip_select_n && !o_write_enable_n && !(o_lower_byte_select_n && o_upper_byte_select_n);
    wire rd_on = !o_chip_select_n && o_write_enable_n && !o_output_enable_n;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////
    property p_no_fight; rd_on |-> o_shared_data_bus_oe == '0; endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives bus in read");
    property p_hold; $past(wr_on) |-> $stable(o_word_address) && o_shared_data_bus_oe == '1; endproperty
    a_hold: assert property (p_hold) else $error("address or data moved in write");
    property p_wr_len; $fell(o_write_enable_n) |-> wr_on ##13 wr_on ##1 !wr_on; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write window length");
    property p_rd_len; $fell(o_output_enable_n) |-> rd_on ##15 rd_on ##1 (!rd_on && o_rsp_valid); endproperty
    a_rd_len: assert property (p_rd_len) else $error("read length or answer");
    property p_turn; $rose(o_output_enable_n) |-> (o_shared_data_bus_oe == '0) [*5]; endproperty
    a_turn: assert property (p_turn) else $error("bus driven too soon");
    property p_idle; o_req_ready |-> !wr_on && !rd_on && o_shared_data_bus_oe == '0; endproperty
    a_idle: assert property (p_idle) else $error("access while idle");
    property p_keep; o_retain_active |-> !wr_on && !rd_on
        && (o_chip_select_n || (o_lower_byte_select_n && o_upper_byte_select_n)); endproperty
    a_keep: assert property (p_keep) else $error("bad retention levels");
    property p_take; i_req_valid && o_req_ready && i_req_byte_en != 2'h0 |=> !o_chip_select_n
        && o_word_address == $past(i_req_addr) && o_write_enable_n == !$past(i_req_write)
        && {o_upper_byte_select_n, o_lower_byte_select_n} == ~$past(i_req_byte_en); endproperty
    a_take: assert property (p_take) else $error("pins do not match request");
endmodule : srhc_ctrl_chk

bind srhc_ctrl srhc_ctrl_chk #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_chk (.*);

// File: test_async_sram_256k_x16.sv
// Self-checking bench for the static memory host controller.
// Assumes the memory model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_async_sram_256k_x16;
    import srhc_pkg::*;
    logic i_ref_clk = 1'h0;
    logic i_reset = 1'h1;
    logic i_req_valid = 1'h0;
    logic i_req_write = 1'h0;
    logic i_retain_req = 1'h0;
    logic i_retain_by_bytes = 1'h0;
    logic [1:0] i_req_byte_en = 2'h0;
    logic [ADDR_W-1:0] i_req_addr = 18'h00000;
    logic [DATA_W-1:0] i_req_wdata = 16'h0000;
    logic [ADDR_W-1:0] o_word_address;
    logic [DATA_W-1:0] o_rsp_rdata, o_shared_data_bus, o_shared_data_bus_oe, i_shared_data_bus, mem_dq;
    logic o_req_ready, o_rsp_valid, o_retain_active, o_chip_select_n, o_write_enable_n;
    logic o_output_enable_n, o_lower_byte_select_n, o_upper_byte_select_n;
    logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
    logic [31:0] seed = 32'h00009BEE;
    int error_cnt = 0;
    int tests_run = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;
    assign i_shared_data_bus = o_shared_data_bus_oe & o_shared_data_bus | ~o_shared_data_bus_oe & mem_dq;
    srhc_ctrl DUT (.*);
    srhc_mem_model u_mem (.i_addr(o_word_address), .i_strb_n({o_chip_select_n, o_write_enable_n,
        o_output_enable_n, o_upper_byte_select_n, o_lower_byte_select_n}), .i_dq(i_shared_data_bus),
        .o_dq(mem_dq), .o_drv());
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [15:0] cur(input logic [17:0] a);
        return shadow.exists(a) ? shadow[a] : ~a[15:0];
    endfunction : cur
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask : tick
    task automatic wait_ready();
        for (int n = 0; n < 64 && o_req_ready !== 1'h1; n++)
            tick();
        check(o_req_ready, 1'h1);
    endtask : wait_ready
    task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
        logic [15:0] w;
        int n;
        wait_ready();
        {i_req_valid, i_req_write, i_req_addr, i_req_wdata, i_req_byte_en} = {1'h1, wr, a, d, be};
        tick();
        i_req_valid = 1'h0;
        w = cur(a);
        if (be == 2'h0) begin
            check({o_chip_select_n, o_req_ready}, 2'h3);
        end else if (wr) begin
            shadow[a] = {be[1] ? d[15:8] : w[15:8], be[0] ? d[7:0] : w[7:0]};
        end else begin
            for (n = 1; n < 40; n++) begin
                tick();
                if (o_rsp_valid === 1'h1)
                    break;
            end
            check(n, 16);
            check(o_rsp_rdata, w & {{8{be[1]}}, {8{be[0]}}});
        end
    endtask : access
    task automatic retain(input logic by_bytes);
        wait_ready();
        i_retain_req = 1'h1;
        i_retain_by_bytes = by_bytes;
        repeat (3) tick();
        check({o_retain_active, o_req_ready, o_chip_select_n}, {2'h2, !by_bytes});
        if (by_bytes) check({o_lower_byte_select_n, o_upper_byte_select_n}, 2'h3);
        // The retention kind must not follow the input once inside
        i_retain_by_bytes = !by_bytes;
        tick();
        check(o_chip_select_n, !by_bytes);
        i_retain_req = 1'h0;
    endtask : retain
    task automatic report_and_stop();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) tick();
        i_reset = 1'h0;
        access(1'h1, 18'h00000, 16'hA55A, 2'h3);
        access(1'h1, 18'h3FFFF, 16'h1234, 2'h3);
        access(1'h1, 18'h00000, 16'hFFFF, 2'h1);
        access(1'h1, 18'h3FFFF, 16'hC3C3, 2'h2);
        access(1'h1, 18'h00001, 16'hBEEF, 2'h0);
        for (int i = 0; i < 6; i++)
            access(1'h0, i[0] ? 18'h3FFFF : 18'h00000, 16'h0000, 2'(3 - i / 2));
        // Reset in mid-read, once the memory has begun to drive
        wait_ready();
        {i_req_valid, i_req_write, i_req_byte_en} = {1'h1, 1'h0, 2'h3};
        tick();
        i_req_valid = 1'h0;
        repeat (12) tick();
        i_reset = 1'h1;
        tick();
        check({o_chip_select_n, o_output_enable_n, o_req_ready, o_rsp_valid, o_shared_data_bus_oe[0]}, 5'h1C);
        i_reset = 1'h0;
        retain(1'h0);
        retain(1'h1);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            access(seed[0], seed[1] ? 18'h3FFFF - seed[4:2] : {15'h0000, seed[4:2]}, seed[31:16], seed[6:5]);
        end
        report_and_stop();
    end
    // About fifty accesses of some twenty-two cycles each
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule : test_async_sram_256k_x16
